// File: mfr_defs.svh
// Constants for the multi-line fast read engine.
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH
`define MFR_OP_DUAL_OUT      8'h3b
`define MFR_OP_DUAL_OUT_4B   8'h3c
`define MFR_OP_DUAL_IO       8'hbb
`define MFR_OP_DUAL_IO_4B    8'hbc
`define MFR_OP_QUAD_OUT      8'h6b
`define MFR_OP_QUAD_OUT_4B   8'h6c
`define MFR_DUMMY_CLKS       6'h08
`define MFR_ADDR_BITS_3B     6'h18
`define MFR_ADDR_BITS_4B     6'h20
`define MFR_OPCODE_BITS      6'h08
`endif

// File: mfr_engine.sv
// Device-side serial engine for dual and quad output fast reads.
// What this block does
// - 3Bh reads data on two lines.
// - Two-line read: address, eight dummy clocks.
// - Input ignored during dummy clocks.
// - 3Ch: two-line read, always 32-bit address.
// - BBh takes address two bits per clock.
// - BCh takes 32-bit address two bits.
// - BBh/BCh: address, dummy, data two-bit.
// - Sample rising edge, shift falling edge.
// - Address increments per byte, wraps to 0.
// - 6Bh: single address, eight dummies, quad.
// - 6Ch: 32-bit address, dummies, quad data.
// - Chip select high ends command anytime.
// - Reads rejected while a cycle busy.
`timescale 1ns/100ps
`include "mfr_defs.svh"
module mfr_engine #(
	parameter int ADDR_W = 25
) (
	// System clock and reset.
	input  wire logic              sys_clk_in,
	input  wire logic              rst_b_in,
	// Serial link pins from the host.
	input  wire logic              sclk_in,
	input  wire logic              cs_b_in,
	input  wire logic              io_line_0_in,
	input  wire logic              io_line_1_in,
	input  wire logic              io_line_2_in,
	input  wire logic              io_line_3_in,
	// Data line drivers; enables are low while driving.
	output logic                   io_line_0_out,
	output logic                   io_line_1_out,
	output logic                   io_line_2_out,
	output logic                   io_line_3_out,
	output logic                   io_line_0_oe_b_out,
	output logic                   io_line_1_oe_b_out,
	output logic                   io_line_2_oe_b_out,
	output logic                   io_line_3_oe_b_out,
	// Device mode and status.
	input  wire logic              four_byte_mode_in,
	input  wire logic              busy_in,
	// Memory read port.
	output logic      [ADDR_W-1:0] mem_addr_out,
	input  wire logic [7:0]        mem_data_in
);
	// Pin handling. Every link pin passes the same two flops, so the serial
	// clock and the data lines keep their relative timing and a rising edge
	// always meets data that has settled for many system clocks. Chip select
	// is carried inverted so that the synchroniser's cleared state reads as
	// deselected; the engine therefore never sees a false selection while
	// the reset is leaving.
	logic [6:0] pins_sync; // Synchronised pin levels.

	// Bring all link pins into the system clock domain.
	mfr_sync #(
		.WIDTH(7)
	) u_sync (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.async_in   ({sclk_in, ~cs_b_in, io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in, 1'b0}),
		.sync_out   (pins_sync)
	);

	logic       sclk_s;  // Synchronised serial clock.
	logic       cs_b_s;  // Synchronised chip select, active low.
	logic [3:0] din_s;   // Synchronised data lines.
	assign sclk_s = pins_sync[6];
	assign cs_b_s = ~pins_sync[5];
	assign din_s  = pins_sync[4:1];

	mfr_pkg::mfr_state_t state_reg;    // Command phase.
	mfr_pkg::mfr_state_t state_next;
	mfr_pkg::mfr_width_t width_reg;    // Lines used per clock in the data phase.
	mfr_pkg::mfr_width_t width_next;
	logic                in_dual_reg;  // Address taken on two lines.
	logic                in_dual_next;
	logic                sclk_d_reg;   // Previous serial clock level.
	logic                sclk_d_next;
	logic [5:0]          bits_reg;     // Bits left in the current phase.
	logic [5:0]          bits_next;
	logic [31:0]         shift_reg;    // Opcode and address shifter.
	logic [31:0]         shift_next;
	logic [ADDR_W-1:0]   addr_reg;     // Read address counter.
	logic [ADDR_W-1:0]   addr_next;
	logic [7:0]          byte_reg;     // Byte being shifted out.
	logic [7:0]          byte_next;
	logic [2:0]          bit_reg;      // Data bits already sent in the byte.
	logic [2:0]          bit_next;
	logic                drive_reg;    // Data lines driven.
	logic                drive_next;
	logic [3:0]          dout_reg;     // Data line output levels.
	logic [3:0]          dout_next;
	logic                rise;         // Serial clock rising edge seen.
	logic                fall;         // Serial clock falling edge seen.

	// Edge detection. The previous level resets low, which is the idle level
	// of the serial clock, so no false edge follows reset.
	assign rise = sclk_s & ~sclk_d_reg;
	assign fall = ~sclk_s & sclk_d_reg;

	// The link clock must stay well below a sixth of the system clock: each
	// serial half period needs at least three system clocks for the two flops,
	// the edge detector and the output register.
	// Phase sequencing, address capture and data shifting.
	always_comb begin
		logic [2:0] step;
		step         = 3'h1;
		state_next   = state_reg;
		width_next   = width_reg;
		in_dual_next = in_dual_reg;
		sclk_d_next  = sclk_s;
		bits_next    = bits_reg;
		shift_next   = shift_reg;
		addr_next    = addr_reg;
		byte_next    = byte_reg;
		bit_next     = bit_reg;
		drive_next   = drive_reg;
		dout_next    = dout_reg;
		unique case (width_reg)
			mfr_pkg::MFR_W1: begin
				step = 3'h1;
			end
			mfr_pkg::MFR_W2: begin
				step = 3'h2;
			end
			mfr_pkg::MFR_W4: begin
				step = 3'h4;
			end
		endcase
		if (cs_b_s) begin
			// Deselect ends any command and releases the lines.
			state_next = mfr_pkg::MFR_IDLE;
			drive_next = 1'b0;
		end else begin
			unique case (state_reg)
				mfr_pkg::MFR_IDLE: begin
					// Selection starts a single-line opcode phase.
					state_next  = mfr_pkg::MFR_OPCODE;
					bits_next   = `MFR_OPCODE_BITS;
					in_dual_next = 1'b0;
					shift_next  = '0;
				end
				mfr_pkg::MFR_OPCODE: begin
					if (rise) begin
						// Opcode bits sampled on the rising edge.
						shift_next = {shift_reg[30:0], din_s[0]};
						bits_next  = bits_reg - 6'h1;
						if (bits_reg == 6'h1) begin
							state_next = mfr_pkg::MFR_ADDR;
							bits_next  = four_byte_mode_in ? `MFR_ADDR_BITS_4B : `MFR_ADDR_BITS_3B;
							// Drop the opcode so that it cannot reach the upper address bits.
							shift_next = '0;
							unique case ({shift_reg[6:0], din_s[0]})
								`MFR_OP_DUAL_OUT: begin
									width_next = mfr_pkg::MFR_W2;
								end
								`MFR_OP_DUAL_OUT_4B: begin
									width_next = mfr_pkg::MFR_W2;
									bits_next  = `MFR_ADDR_BITS_4B;
								end
								`MFR_OP_DUAL_IO: begin
									width_next   = mfr_pkg::MFR_W2;
									in_dual_next = 1'b1;
								end
								`MFR_OP_DUAL_IO_4B: begin
									width_next   = mfr_pkg::MFR_W2;
									in_dual_next = 1'b1;
									bits_next    = `MFR_ADDR_BITS_4B;
								end
								`MFR_OP_QUAD_OUT: begin
									width_next = mfr_pkg::MFR_W4;
								end
								`MFR_OP_QUAD_OUT_4B: begin
									width_next = mfr_pkg::MFR_W4;
									bits_next  = `MFR_ADDR_BITS_4B;
								end
								default: begin
									state_next = mfr_pkg::MFR_IGNORE;
								end
							endcase
							// A read during a busy cycle is dropped untouched.
							if (busy_in) begin
								state_next = mfr_pkg::MFR_IGNORE;
							end
						end
					end
				end
				mfr_pkg::MFR_ADDR: begin
					if (rise) begin
						// Address bits enter on rising edges, one or two per clock.
						if (in_dual_reg) begin
							shift_next = {shift_reg[29:0], din_s[1:0]};
							bits_next  = bits_reg - 6'h2;
						end else begin
							shift_next = {shift_reg[30:0], din_s[0]};
							bits_next  = bits_reg - 6'h1;
						end
						if (bits_reg == (in_dual_reg ? 6'h2 : 6'h1)) begin
							state_next = mfr_pkg::MFR_DUMMY;
							bits_next  = `MFR_DUMMY_CLKS;
							addr_next  = in_dual_reg ? ADDR_W'({shift_reg[29:0], din_s[1:0]})
								: ADDR_W'({shift_reg[30:0], din_s[0]});
						end
					end
				end
				mfr_pkg::MFR_DUMMY: begin
					// Input lines are not looked at here.
					if (rise) begin
						bits_next = bits_reg - 6'h1;
						if (bits_reg == 6'h1) begin
							// The first byte is taken here, half a serial clock before it leaves.
							state_next = mfr_pkg::MFR_DATA;
							byte_next  = mem_data_in;
							bit_next   = 3'h0;
							addr_next  = addr_reg + ADDR_W'(1);
						end
					end
				end
				mfr_pkg::MFR_DATA: begin
					if (fall) begin
						// Data shifts out on falling edges, top bits first.
						drive_next = 1'b1;
						dout_next  = '0;
						unique case (width_reg)
							mfr_pkg::MFR_W4: begin
								dout_next = byte_reg[7:4];
								byte_next = {byte_reg[3:0], 4'h0};
							end
							mfr_pkg::MFR_W2: begin
								dout_next[1:0] = byte_reg[7:6];
								byte_next      = {byte_reg[5:0], 2'h0};
							end
							default: begin
								dout_next[1] = byte_reg[7];
								byte_next    = {byte_reg[6:0], 1'b0};
							end
						endcase
						bit_next = bit_reg + step;
						if (bit_reg + step == 3'h0) begin
							// Byte done: fetch next, address wraps past top.
							byte_next = mem_data_in;
							addr_next = addr_reg + ADDR_W'(1);
						end
					end
				end
				mfr_pkg::MFR_IGNORE: begin
					// Stay quiet until deselected.
					drive_next = 1'b0;
				end
				default: begin
					state_next = mfr_pkg::MFR_IDLE;
				end
			endcase
		end
	end

	// Register the engine state.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg   <= mfr_pkg::MFR_IDLE;
			width_reg   <= mfr_pkg::MFR_W1;
			in_dual_reg <= 1'b0;
			sclk_d_reg  <= 1'b0;
			bits_reg    <= 6'h0;
			shift_reg   <= 32'h0;
			addr_reg    <= '0;
			byte_reg    <= 8'h0;
			bit_reg     <= 3'h0;
			drive_reg   <= 1'b0;
			dout_reg    <= 4'h0;
		end else begin
			state_reg   <= state_next;
			width_reg   <= width_next;
			in_dual_reg <= in_dual_next;
			sclk_d_reg  <= sclk_d_next;
			bits_reg    <= bits_next;
			shift_reg   <= shift_next;
			addr_reg    <= addr_next;
			byte_reg    <= byte_next;
			bit_reg     <= bit_next;
			drive_reg   <= drive_next;
			dout_reg    <= dout_next;
		end
	end

	// Lines 0 and 1 share one enable in every read, and lines 2 and 3 follow
	// only in four-line reads, so a two-line read leaves the upper pair to the
	// host or its pull-ups.
	// Line drivers; lines 2 and 3 drive only in four-line reads.
	assign io_line_0_out      = dout_reg[0];
	assign io_line_1_out      = dout_reg[1];
	assign io_line_2_out      = dout_reg[2];
	assign io_line_3_out      = dout_reg[3];
	assign io_line_0_oe_b_out = ~drive_reg;
	assign io_line_1_oe_b_out = ~drive_reg;
	assign io_line_2_oe_b_out = ~(drive_reg && (width_reg == mfr_pkg::MFR_W4));
	assign io_line_3_oe_b_out = ~(drive_reg && (width_reg == mfr_pkg::MFR_W4));
	assign mem_addr_out       = addr_reg;
endmodule

// File: mfr_host.sv
// Host controller model driving the serial link.
`timescale 1ns/100ps
module mfr_host (
	// Link drive; a line is driven where its enable is high.
	output logic            sclk_out,
	output logic            cs_b_out,
	output logic [3:0]      io_out,
	output logic [3:0]      io_en_out,
	// Resolved line levels.
	input  wire logic [3:0] io_in
);
	logic [7:0] got[$]; // Bytes taken in the last read.
	initial begin
		sclk_out = 1'b0;
		cs_b_out = 1'b1;
		io_out = 4'hc;
		io_en_out = 4'h0;
	end
	// One clock carrying v; all drives drop before the fall when rel is set.
	task automatic tick(input logic [3:0] v, input bit rel);
		io_out = v;
		#62.5 sclk_out = 1'b1;
		#62.5 if (rel) io_en_out = 4'h0;
		sclk_out = 1'b0;
	endtask
	// Opcode, address, dummy clocks, n bytes, then part extra groups.
	task automatic read(input logic [7:0] op, input logic [31:0] a, input int ab, aw, dw, n, part,
		input logic [15:0] dp);
		logic [7:0] cur;
		// Start off the system clock grid so that no pin change races its sampling.
		#1.3;
		got.delete();
		cs_b_out = 1'b0;
		io_en_out = (dw == 4) ? 4'hd : 4'h1;
		for (int i = 7; i >= 0; i--) tick({3'h6, op[i]}, 1'b0);
		io_en_out[1] = (aw == 2);
		for (int i = ab - aw; i >= 0; i -= aw) tick({2'h3, a[i +: 2]}, 1'b0);
		for (int i = 0; i < 8; i++) tick({2'h3, dp[2*i +: 2]}, i == 7);
		for (int g = 0; g < n * 8 / dw + part; g++) begin
			#62.5 cur = (dw == 4) ? {cur[3:0], io_in} : {cur[5:0], io_in[1:0]};
			sclk_out = 1'b1;
			if (g % (8 / dw) == 8 / dw - 1) got.push_back(cur);
			#62.5 sclk_out = 1'b0;
		end
		#62.5 cs_b_out = 1'b1;
		#250;
	endtask
endmodule

// File: mfr_pkg.sv
// Types for the multi-line fast read engine.
package mfr_pkg;
	typedef enum logic [2:0] {
		MFR_IDLE,
		MFR_OPCODE,
		MFR_ADDR,
		MFR_DUMMY,
		MFR_DATA,
		MFR_IGNORE
	} mfr_state_t;
	typedef enum logic [1:0] {
		MFR_W1,
		MFR_W2,
		MFR_W4
	} mfr_width_t;
endpackage

// File: mfr_props.sv
// Pin checker for the fast read engine.
`timescale 1ns/100ps
module mfr_props #(
	parameter int ADDR_W = 25
) (
	// Clock, reset, link and status.
	input wire logic              sys_clk_in,
	input wire logic              rst_b_in,
	input wire logic              sclk_in,
	input wire logic              cs_b_in,
	input wire logic              busy_in,
	// Device drivers.
	input wire logic              io_line_0_out,
	input wire logic              io_line_0_oe_b_out,
	input wire logic              io_line_1_oe_b_out,
	input wire logic              io_line_2_oe_b_out,
	input wire logic              io_line_3_oe_b_out,
	input wire logic [ADDR_W-1:0] mem_addr_out
);
	logic [3:0] fall_reg, fall_next; // Cycles since sclk fell.
	logic       sclk_reg;            // Sclk one cycle back.
	logic       blk_reg, blk_next;   // Busy since select.
	logic       rel;                 // No line driven.
	assign rel = &{io_line_0_oe_b_out, io_line_1_oe_b_out, io_line_2_oe_b_out, io_line_3_oe_b_out};
	// Next helper values.
	always_comb begin
		fall_next = (sclk_reg && !sclk_in) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hf};
		blk_next = cs_b_in | (blk_reg & busy_in);
	end
	// Helper registers.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fall_reg <= 4'hf;
			sclk_reg <= 1'b0;
			blk_reg <= 1'b1;
		end else begin
			fall_reg <= fall_next;
			sclk_reg <= sclk_in;
			blk_reg <= blk_next;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_rel; cs_b_in [*5] |-> rel; endproperty
	a_rel: assert property (p_rel) else $error("driven while deselected");
	property p_dual; io_line_0_oe_b_out == io_line_1_oe_b_out; endproperty
	a_dual: assert property (p_dual) else $error("lines 0 and 1 apart");
	property p_quad; io_line_2_oe_b_out == io_line_3_oe_b_out; endproperty
	a_quad: assert property (p_quad) else $error("lines 2 and 3 apart");
	property p_quad_all; !io_line_2_oe_b_out |-> !io_line_0_oe_b_out; endproperty
	a_quad_all: assert property (p_quad_all) else $error("quad without low lines");
	property p_shift; !io_line_0_oe_b_out && !$past(io_line_0_oe_b_out) && $changed(io_line_0_out)
		|-> fall_reg inside {[4'h1:4'h7]}; endproperty
	a_shift: assert property (p_shift) else $error("data moved off a fall");
	property p_start; $fell(io_line_0_oe_b_out) |-> fall_reg inside {[4'h1:4'h7]}; endproperty
	a_start: assert property (p_start) else $error("drive began off a fall");
	property p_incr; $changed(mem_addr_out) && !$past(io_line_0_oe_b_out) && !cs_b_in
		|-> mem_addr_out == $past(mem_addr_out) + 1'b1; endproperty
	a_incr: assert property (p_incr) else $error("address step not one");
	property p_busy; blk_reg && !cs_b_in |-> rel; endproperty
	a_busy: assert property (p_busy) else $error("read served while busy");
	c_quad: cover property (!io_line_3_oe_b_out);
	c_abort: cover property (!io_line_0_oe_b_out && cs_b_in);
	c_busy: cover property (blk_reg && !cs_b_in);
endmodule

// File: mfr_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module mfr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             sys_clk_in,
	input  wire logic             rst_b_in,
	// Asynchronous input and synchronised output.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second.
	logic [WIDTH-1:0] meta_next; // Next value of the first stage.
	logic [WIDTH-1:0] sync_reg;  // Second stage.
	logic [WIDTH-1:0] sync_next; // Next value of the second stage.

	// Shift the pin value through two stages.
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// Register both stages.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

// File: tb_multi_io_fast_read_engine.sv
// Testbench for the multi-line fast read engine.
`timescale 1ns/100ps
module tb_multi_io_fast_read_engine;
	localparam int AW = 25;           // Address width under test.
	logic          sys_clk_in = 1'b0; // System clock.
	logic          rst_b_in = 1'b0;   // Reset, active low.
	logic          mode4_reg = 1'b0;  // 32-bit address mode.
	logic          busy_reg = 1'b0;   // Write cycle in progress.
	logic          junk_reg = 1'b0;   // Level of an undriven line.
	logic          sclk, cs_b;        // Host clock and select.
	logic [3:0]    h_out, h_en, lvl;  // Host drive and line levels.
	logic [3:0]    d_out, d_oe_b;     // Device drive.
	logic [AW-1:0] addr;              // Memory read address.
	logic [7:0]    ops [6] = '{8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b, 8'h6c};
	int            bad_count = 0;
	int            num_checks = 0;
	int            drv_cnt = 0;       // Cycles with a line driven.
	int            seed = 32'ha719c3c0;
	// Memory contents as a function of the address.
	function automatic logic [7:0] memf(input logic [AW-1:0] a);
		return a[7:0] ^ a[15:8] ^ {a[24], 7'h2d};
	endfunction
	mfr_host host (.sclk_out(sclk), .cs_b_out(cs_b), .io_out(h_out), .io_en_out(h_en), .io_in(lvl));
	mfr_engine #(.ADDR_W(AW)) uut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_b_in(cs_b),
		.io_line_0_in(lvl[0]), .io_line_1_in(lvl[1]), .io_line_2_in(lvl[2]), .io_line_3_in(lvl[3]),
		.io_line_0_out(d_out[0]), .io_line_1_out(d_out[1]), .io_line_2_out(d_out[2]), .io_line_3_out(d_out[3]),
		.io_line_0_oe_b_out(d_oe_b[0]), .io_line_1_oe_b_out(d_oe_b[1]), .io_line_2_oe_b_out(d_oe_b[2]),
		.io_line_3_oe_b_out(d_oe_b[3]), .four_byte_mode_in(mode4_reg), .busy_in(busy_reg),
		.mem_addr_out(addr), .mem_data_in(memf(addr)));
	// A line carries the device, else the host, else a toggling level.
	always_comb begin
		for (int i = 0; i < 4; i++) lvl[i] = !d_oe_b[i] ? d_out[i] : h_en[i] ? h_out[i] : junk_reg;
	end
	initial forever #4 sys_clk_in = ~sys_clk_in;
	// Toggle the idle level and count drive cycles.
	always @(posedge sys_clk_in) begin
		junk_reg <= !junk_reg;
		if (d_oe_b != 4'hf) drv_cnt++;
	end
	// Compares a byte and counts the result.
	task automatic chk_byte(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One read; checks the bytes, or silence when refused, and the release.
	task automatic run(input logic [7:0] op, input logic [31:0] a0, input bit m4, bsy, input int n, part);
		int ab;
		int d0;
		logic [31:0] a;
		bit ok;
		ab = (!op[0] || m4) ? 32 : 24;
		a = (ab == 24) ? {8'h0, a0[23:0]} : a0;
		ok = !bsy && (op inside {ops});
		@(posedge sys_clk_in);
		mode4_reg <= m4;
		busy_reg <= bsy;
		@(posedge sys_clk_in);
		d0 = drv_cnt;
		host.read(op, a, ab, (op[7:4] == 4'hb) ? 2 : 1, (op[7:4] == 4'h6) ? 4 : 2, n, part, 16'($random(seed)));
		repeat (6) @(posedge sys_clk_in);
		chk_byte({4'h0, d_oe_b}, 8'h0f);
		if (!ok) chk_byte({7'h0, drv_cnt != d0}, 8'h00);
		for (int i = 0; ok && i < n; i++) chk_byte(host.got[i], memf(AW'(a + i)));
		if (ok) chk_byte(8'(host.got.size()), 8'(n));
		$display("op %h at %h done", op, a);
	endtask
	// Main sequence.
	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		for (int k = 0; k < 12; k++) run(ops[k % 6], $random(seed), k >= 6, 1'b0, 3, 0);
		run(8'h6c, 32'h01fffffe, 1'b0, 1'b0, 4, 0);
		run(8'hbb, 32'h00fffffe, 1'b0, 1'b0, 3, 0);
		run(8'h3b, $random(seed), 1'b0, 1'b1, 2, 0);
		run(8'h5a, $random(seed), 1'b1, 1'b0, 2, 0);
		run(8'h6b, $random(seed), 1'b1, 1'b0, 0, 1);
		run(8'hbc, $random(seed), 1'b0, 1'b0, 1, 3);
		conclude();
	end
	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		bad_count++;
		$display("ERROR %0t run too long", $time);
		conclude();
	end
endmodule
bind mfr_engine mfr_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.sclk_in(sclk_in), .cs_b_in(cs_b_in), .busy_in(busy_in), .io_line_0_out(io_line_0_out),
	.io_line_0_oe_b_out(io_line_0_oe_b_out), .io_line_1_oe_b_out(io_line_1_oe_b_out),
	.io_line_2_oe_b_out(io_line_2_oe_b_out), .io_line_3_oe_b_out(io_line_3_oe_b_out), .mem_addr_out(mem_addr_out));
